// ### hw/gpio_bank_pkg.sv
// Constants shared by the GPIO input and output bank registers
package gpio_bank_pkg;

    localparam int BANK_COUNT  = 6;
    localparam int REG_WIDTH   = 32;
    localparam int PIN_COUNT   = BANK_COUNT * REG_WIDTH;
    localparam int ADDR_WIDTH  = 12;
    localparam int SYNC_STAGES = 2;

    // Register offsets, byte addresses
    localparam logic [ADDR_WIDTH-1:0] PIN_INPUT_BANK_0_OFFSET  = 12'h300;
    localparam logic [ADDR_WIDTH-1:0] PIN_INPUT_BANK_1_OFFSET  = 12'h304;
    localparam logic [ADDR_WIDTH-1:0] PIN_INPUT_BANK_2_OFFSET  = 12'h308;
    localparam logic [ADDR_WIDTH-1:0] PIN_INPUT_BANK_3_OFFSET  = 12'h30C;
    localparam logic [ADDR_WIDTH-1:0] PIN_INPUT_BANK_4_OFFSET  = 12'h310;
    localparam logic [ADDR_WIDTH-1:0] PIN_INPUT_BANK_5_OFFSET  = 12'h314;
    localparam logic [ADDR_WIDTH-1:0] PIN_OUTPUT_BANK_0_OFFSET = 12'h380;
    localparam logic [ADDR_WIDTH-1:0] PIN_OUTPUT_BANK_1_OFFSET = 12'h384;
    localparam logic [ADDR_WIDTH-1:0] PIN_OUTPUT_BANK_2_OFFSET = 12'h388;
    localparam logic [ADDR_WIDTH-1:0] PIN_OUTPUT_BANK_3_OFFSET = 12'h38C;
    localparam logic [ADDR_WIDTH-1:0] PIN_OUTPUT_BANK_4_OFFSET = 12'h390;
    localparam logic [ADDR_WIDTH-1:0] PIN_OUTPUT_BANK_5_OFFSET = 12'h394;

    // Field positions inside one bank register
    localparam int FIELD_0_LSB   = 0;
    localparam int FIELD_1_LSB   = 8;
    localparam int FIELD_2_LSB   = 16;
    localparam int FIELD_3_LSB   = 24;
    localparam int FIELD_3_MSB   = 30;
    localparam int RESERVED_BIT  = 31;
    localparam int FIELD_WIDTH   = 8;
    localparam int FIELDS_PER_REG = 4;

    // Reset values
    localparam logic [FIELD_WIDTH-1:0] FIELD_RESET = 8'h00;
    localparam logic [REG_WIDTH-1:0]   REG_RESET   = 32'h0000_0000;

    // Bits that hold pins; bit 31 never does
    localparam logic [REG_WIDTH-1:0] BANK_FIELD_MASK = 32'h7FFF_FFFF;

    // Bonded pins per package variant; one bit per pin, bank-major
    localparam logic [PIN_COUNT-1:0] BONDED_PINS = {BANK_COUNT{BANK_FIELD_MASK}};

    // Pin function select: the GPIO function code
    localparam int                     FUNC_SEL_WIDTH = 2;
    localparam logic [FUNC_SEL_WIDTH-1:0] FUNC_GPIO   = 2'h0;

    // First writable input bank index; unused, writes to every input bank change nothing
    localparam int INPUT_WRITABLE_FIRST = 4;

endpackage : gpio_bank_pkg

// ### hw/gpio_pin_sync.sv
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stable_r;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r   <= '0;
            stable_r <= '0;
        end else begin
            meta_r   <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule : gpio_pin_sync

`default_nettype wire

// ### hw/gpio_parallel_in_out_banks.sv
// GPIO input and output bank registers with pin drive control
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module gpio_parallel_in_out_banks (
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    input  wire logic [11:0]                  reg_addr,
    input  wire logic [31:0]                  reg_wr_data,
    input  wire logic                         reg_wr_en,
    input  wire logic                         reg_rd_en,
    output logic      [31:0]                  reg_rd_data,
    input  wire logic [191:0]                 pin_level_in,
    input  wire logic [191:0]                 output_select_en,
    input  wire logic [383:0]                 pin_function_select,
    output logic      [191:0]                 pin_level_out,
    output logic      [191:0]                 pin_drive_en
);

    localparam int NB  = gpio_bank_pkg::BANK_COUNT;
    localparam int RW  = gpio_bank_pkg::REG_WIDTH;
    localparam int NP  = gpio_bank_pkg::PIN_COUNT;
    localparam int AW  = gpio_bank_pkg::ADDR_WIDTH;
    localparam int FSW = gpio_bank_pkg::FUNC_SEL_WIDTH;
    localparam int FW  = gpio_bank_pkg::FIELD_WIDTH;
    localparam int NF  = gpio_bank_pkg::FIELDS_PER_REG;

    // Offset lookup for the input banks
    function automatic logic [AW-1:0] input_offset(input int bank);
        logic [AW-1:0] off;
        off = gpio_bank_pkg::PIN_INPUT_BANK_0_OFFSET;
        case (bank)
            0: begin
                off = gpio_bank_pkg::PIN_INPUT_BANK_0_OFFSET;
            end
            1: begin
                off = gpio_bank_pkg::PIN_INPUT_BANK_1_OFFSET;
            end
            2: begin
                off = gpio_bank_pkg::PIN_INPUT_BANK_2_OFFSET;
            end
            3: begin
                off = gpio_bank_pkg::PIN_INPUT_BANK_3_OFFSET;
            end
            4: begin
                off = gpio_bank_pkg::PIN_INPUT_BANK_4_OFFSET;
            end
            default: begin
                off = gpio_bank_pkg::PIN_INPUT_BANK_5_OFFSET;
            end
        endcase
        return off;
    endfunction : input_offset

    // Offset lookup for the output banks
    function automatic logic [AW-1:0] output_offset(input int bank);
        logic [AW-1:0] off;
        off = gpio_bank_pkg::PIN_OUTPUT_BANK_0_OFFSET;
        case (bank)
            0: begin
                off = gpio_bank_pkg::PIN_OUTPUT_BANK_0_OFFSET;
            end
            1: begin
                off = gpio_bank_pkg::PIN_OUTPUT_BANK_1_OFFSET;
            end
            2: begin
                off = gpio_bank_pkg::PIN_OUTPUT_BANK_2_OFFSET;
            end
            3: begin
                off = gpio_bank_pkg::PIN_OUTPUT_BANK_3_OFFSET;
            end
            4: begin
                off = gpio_bank_pkg::PIN_OUTPUT_BANK_4_OFFSET;
            end
            default: begin
                off = gpio_bank_pkg::PIN_OUTPUT_BANK_5_OFFSET;
            end
        endcase
        return off;
    endfunction : output_offset

    // Synchronised pin levels
    logic [NP-1:0]      pin_sync;

    // Per-bank decode results
    logic [NB-1:0]      in_hit;
    logic [NB-1:0]      out_hit;
    logic [NB-1:0]      out_wr;

    // Per-bank register views
    logic [RW-1:0]      in_view   [NB];
    logic [RW-1:0]      out_r     [NB];
    logic [RW-1:0]      out_nxt   [NB];
    logic [RW-1:0]      rd_term   [NB];

    // Per-pin drive decode
    logic [NP-1:0]      gpio_func;
    logic [NP-1:0]      drive_en_nxt;
    logic [NP-1:0]      drive_en_r;

    // Read path
    logic               any_hit;
    logic [RW-1:0]      rd_mux;
    logic [RW-1:0]      rd_data_nxt;
    logic [RW-1:0]      rd_data_r;

    // Pin levels cross into the register clock before any use
    gpio_pin_sync #(
        .WIDTH    (NP)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (pin_level_in),
        .sync_out (pin_sync)
    );

    genvar b;
    genvar p;

    generate
        for (b = 0; b < NB; b++) begin : g_bank

            // Exact word match; misaligned or other addresses miss
            assign in_hit[b]  = (reg_addr == input_offset(b));
            assign out_hit[b] = (reg_addr == output_offset(b));

            // Output bank write strobe
            assign out_wr[b] = reg_wr_en & out_hit[b];

            // Input view: current level, unbonded and reserved bits zero
            // No store behind it, so writes to any input bank change nothing
            assign in_view[b] = pin_sync[b*RW +: RW]
                              & gpio_bank_pkg::BONDED_PINS[b*RW +: RW]
                              & gpio_bank_pkg::BANK_FIELD_MASK;

            // Only live, bonded bits store a write
            assign out_nxt[b] = out_wr[b]
                              ? (reg_wr_data
                                 & gpio_bank_pkg::BONDED_PINS[b*RW +: RW]
                                 & gpio_bank_pkg::BANK_FIELD_MASK)
                              : out_r[b];

            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    out_r[b] <= gpio_bank_pkg::REG_RESET;
                end else begin
                    out_r[b] <= out_nxt[b];
                end
            end

            // Output bank reads return the stored value whatever the pin does; input bank reads return the synchronised level
            assign rd_term[b] = (in_hit[b]  ? in_view[b] : '0)
                              | (out_hit[b] ? out_r[b]   : '0);

            // Each bank pin drives its pad level from the stored bit
            assign pin_level_out[b*RW +: RW] = out_r[b];

            for (p = 0; p < RW; p++) begin : g_pin
                // Pin uses the GPIO function when its select code matches
                assign gpio_func[b*RW+p] =
                    (pin_function_select[(b*RW+p)*FSW +: FSW]
                     == gpio_bank_pkg::FUNC_GPIO);

                // Drive only enabled, GPIO-function, bonded, live pins
                assign drive_en_nxt[b*RW+p] = output_select_en[b*RW+p]
                                            & gpio_func[b*RW+p]
                                            & gpio_bank_pkg::BONDED_PINS[b*RW+p]
                                            & gpio_bank_pkg::BANK_FIELD_MASK[p];
            end : g_pin

        end : g_bank
    endgenerate

    // Field layout check values for the read mux, per byte lane
    logic [FW-1:0] rd_field [NF];

    always_comb begin
        rd_mux = '0;
        for (int i = 0; i < NB; i++) begin
            rd_mux = rd_mux | rd_term[i];
        end
    end

    // Split into the four octal-group fields; bit 31 stays zero
    assign rd_field[0] = rd_mux[gpio_bank_pkg::FIELD_0_LSB +: FW];
    assign rd_field[1] = rd_mux[gpio_bank_pkg::FIELD_1_LSB +: FW];
    assign rd_field[2] = rd_mux[gpio_bank_pkg::FIELD_2_LSB +: FW];
    assign rd_field[3] = {1'b0,
        rd_mux[gpio_bank_pkg::FIELD_3_MSB:gpio_bank_pkg::FIELD_3_LSB]};

    assign any_hit = |in_hit | |out_hit;

    // Unmapped addresses read zero; data stands one cycle only
    assign rd_data_nxt = (reg_rd_en && any_hit)
                       ? {rd_field[3], rd_field[2], rd_field[1], rd_field[0]}
                       : gpio_bank_pkg::REG_RESET;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= gpio_bank_pkg::REG_RESET;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    // Pad enables registered so the ports come from flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_en_r <= '0;
        end else begin
            drive_en_r <= drive_en_nxt;
        end
    end

    assign reg_rd_data  = rd_data_r;
    assign pin_drive_en = drive_en_r;

endmodule : gpio_parallel_in_out_banks

`default_nettype wire

// ### testbench/gpio_parallel_in_out_banks_properties.sv
// Port checker for the GPIO bank register block
`timescale 1ns/1ps
`default_nettype none

module gpio_bank_properties (
    input wire logic         sys_clk,
    input wire logic         rst_n,
    input wire logic [11:0]  reg_addr,
    input wire logic [31:0]  reg_wr_data,
    input wire logic         reg_wr_en,
    input wire logic         reg_rd_en,
    input wire logic [31:0]  reg_rd_data,
    input wire logic [383:0] pin_function_select,
    input wire logic [191:0] output_select_en,
    input wire logic [191:0] pin_level_out,
    input wire logic [191:0] pin_drive_en
);
    logic [191:0] gpio_fn;
    logic         mapped;

    for (genvar i = 0; i < 192; i++) begin : g_fn
        assign gpio_fn[i] = pin_function_select[2*i +: 2] == gpio_bank_pkg::FUNC_GPIO;
    end
    assign mapped = reg_addr[1:0] == 2'h0 && ((reg_addr >= 12'h300 && reg_addr <= 12'h314)
                    || (reg_addr >= 12'h380 && reg_addr <= 12'h394));

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_drive_en;
        $past(rst_n) |-> pin_drive_en ==
            $past(output_select_en & gpio_fn & gpio_bank_pkg::BONDED_PINS);
    endproperty
    a_drive_en: assert property (p_drive_en) else $error("drive enable wrong");
    property p_rd_idle;
        !reg_rd_en |=> reg_rd_data == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_out0_wr;
        reg_wr_en && reg_addr == 12'h380 |=>
            pin_level_out[31:0] == ($past(reg_wr_data) & 32'h7FFF_FFFF);
    endproperty
    a_out0_wr: assert property (p_out0_wr) else $error("bank 0 write lost");
    property p_out5_wr;
        reg_wr_en && reg_addr == 12'h394 |=>
            pin_level_out[191:160] == ($past(reg_wr_data) & 32'h7FFF_FFFF);
    endproperty
    a_out5_wr: assert property (p_out5_wr) else $error("bank 5 write lost");
    property p_rd_back;
        reg_rd_en && reg_addr == 12'h384 |=> reg_rd_data == $past(pin_level_out[63:32]);
    endproperty
    a_rd_back: assert property (p_rd_back) else $error("readback differs");
    property p_unmapped;
        reg_rd_en && !mapped |=> reg_rd_data == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_out_rsv;
        (pin_level_out & ~gpio_bank_pkg::BONDED_PINS) == 192'h0;
    endproperty
    a_out_rsv: assert property (p_out_rsv) else $error("reserved output bit set");
    property p_rd_rsv;
        reg_rd_en |=> !reg_rd_data[31];
    endproperty
    a_rd_rsv: assert property (p_rd_rsv) else $error("bit 31 read set");
    property p_out_hold;
        !reg_wr_en |=> $stable(pin_level_out);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output moved without write");
endmodule : gpio_bank_properties

bind gpio_parallel_in_out_banks gpio_bank_properties u_gpio_bank_properties (
    .sys_clk, .rst_n, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en, .reg_rd_data,
    .pin_function_select, .output_select_en, .pin_level_out, .pin_drive_en
);

`default_nettype wire

// ### testbench/test_gpio_parallel_in_out_banks.sv
// Self-checking bench for the GPIO bank register block
`timescale 1ns/1ps
`default_nettype none

module test_gpio_parallel_in_out_banks;
    logic         sys_clk = 0, rst_n = 0, reg_wr_en = 0, reg_rd_en = 0, rd_seen = 0;
    logic [11:0]  reg_addr = 12'h000;
    logic [31:0]  reg_wr_data = 32'h0, reg_rd_data, d;
    logic [191:0] pin_level_in = '0, output_select_en = '0, pin_level_out, pin_drive_en, e;
    logic [383:0] pin_function_select = '0;
    logic [31:0]  exp_q[$];
    logic [11:0]  bad_addr[4] = '{12'h318, 12'h37C, 12'h398, 12'h382};
    int           fail_count = 0, comparisons = 0, seed = 32'h75305c84;

    gpio_parallel_in_out_banks u_gpio_parallel_in_out_banks (.sys_clk, .rst_n, .reg_addr,
        .reg_wr_data, .reg_wr_en, .reg_rd_en, .reg_rd_data, .pin_level_in, .output_select_en,
        .pin_function_select, .pin_level_out, .pin_drive_en);

    task automatic check(input logic [191:0] seen, input logic [191:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic acc(input logic r, w, input logic [11:0] a, input logic [31:0] v, x);
        if (r) exp_q.push_back(x);
        reg_rd_en   <= r;
        reg_wr_en   <= w;
        reg_addr    <= a;
        reg_wr_data <= v;
        @(posedge sys_clk);
    endtask : acc

    task automatic finish_test;
        $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    initial forever #4 sys_clk = ~sys_clk;

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (rd_seen) check(192'(reg_rd_data), 192'(exp_q.pop_front()));
        rd_seen = reg_rd_en;
    end

    initial begin
        #(8 * 3000);
        fail_count++;
        finish_test;
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            acc(1, 0, 12'h300 + 12'(4 * i), 0, 0);
            acc(1, 0, 12'h380 + 12'(4 * i), 0, 0);
        end
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            e[32*i +: 32] = d & gpio_bank_pkg::BANK_FIELD_MASK;
            acc(0, 1, 12'h380 + 12'(4 * i), d, 0);
        end
        acc(0, 1, 12'h300, 32'hFFFF_FFFF, 0);
        acc(0, 1, 12'h398, 32'hFFFF_FFFF, 0);
        for (int i = 0; i < 6; i++) acc(1, 0, 12'h380 + 12'(4 * i), 0, e[32*i +: 32]);
        #1 check(pin_level_out, e);
        $display("test output banks done");
        for (int i = 0; i < 6; i++) pin_level_in[32*i +: 32] <= $random(seed);
        repeat (3) acc(0, 0, 12'h000, 0, 0);
        for (int i = 0; i < 6; i++)
            acc(1, 0, 12'h300 + 12'(4 * i), 0, pin_level_in[32*i +: 32] & 32'h7FFF_FFFF);
        acc(0, 1, 12'h310, $random(seed), 0);
        acc(1, 0, 12'h310, 0, pin_level_in[128 +: 32] & 32'h7FFF_FFFF);
        foreach (bad_addr[i]) acc(1, 0, bad_addr[i], 0, 0);
        $display("test input banks done");
        for (int n = 0; n < 4; n++) begin
            for (int j = 0; j < 6; j++) output_select_en[32*j +: 32] <= $random(seed);
            for (int j = 0; j < 12; j++) pin_function_select[32*j +: 32] <= $random(seed);
            repeat (2) acc(0, 0, 12'h000, 0, 0);
            for (int k = 0; k < 192; k++)
                e[k] = output_select_en[k] && gpio_bank_pkg::BONDED_PINS[k]
                       && pin_function_select[2*k +: 2] == gpio_bank_pkg::FUNC_GPIO;
            #1 check(pin_drive_en, e);
        end
        $display("test drive enable done");
        rst_n <= 1'b0;
        acc(0, 0, 12'h000, 0, 0);
        #1 check(pin_level_out, 192'h0);
        check(pin_drive_en, 192'h0);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        acc(1, 0, 12'h394, 0, 0);
        repeat (2) acc(0, 0, 12'h000, 0, 0);
        $display("test second reset done");
        finish_test;
    end
endmodule : test_gpio_parallel_in_out_banks

`default_nettype wire
